/* shared/charger_cfg_pkg.sv */
package charger_cfg_pkg;

  // Serial interface identity and address space.
  localparam logic [6:0] SLAVE_ADDR = 7'h4b;
  localparam int NUM_REGS = 14;
  localparam logic [7:0] LAST_OFFSET = 8'h0d;
  localparam logic [7:0] BEYOND_MAP_VALUE = 8'hff;

  // Register offsets.
  localparam logic [7:0] OFS_CHARGE_VOLTAGE_LIMIT = 8'h00;
  localparam logic [7:0] OFS_FAST_CHARGE_CURRENT_LIMIT = 8'h01;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_FLOOR = 8'h02;
  localparam logic [7:0] OFS_INPUT_CURRENT_CAP = 8'h03;
  localparam logic [7:0] OFS_RESERVED_SLOT_FOUR = 8'h04;
  localparam logic [7:0] OFS_CHARGER_CONTROL_FIRST = 8'h05;
  localparam logic [7:0] OFS_CHARGER_CONTROL_SECOND = 8'h06;
  localparam logic [7:0] OFS_INTERRUPT_CONDITION_STATE = 8'h07;
  localparam logic [7:0] OFS_FAULT_CONDITION_STATE = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_EVENT_LATCH = 8'h09;
  localparam logic [7:0] OFS_FAULT_EVENT_LATCH = 8'h0a;
  localparam logic [7:0] OFS_INTERRUPT_EVENT_MASK = 8'h0b;
  localparam logic [7:0] OFS_FAULT_EVENT_MASK = 8'h0c;
  localparam logic [7:0] OFS_PART_IDENTIFICATION = 8'h0d;

  // Values after reset, writable bits, and bits restored by watchdog expiry, by offset.
  localparam logic [7:0] RESET_VALUE [NUM_REGS] = '{8'haa, 8'h46, 8'h04, 8'h13, 8'h03,
    8'h9d, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WRITE_MASK [NUM_REGS] = '{8'hff, 8'h7f, 8'h7f, 8'h3f, 8'h00,
    8'hff, 8'h3b, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] WDT_MASK [NUM_REGS] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Code limits of the three clamped charger limit fields.
  localparam logic [6:0] FCC_CODE_MAX = 7'h78;
  localparam logic [6:0] FCC_CODE_MIN = 7'h06;
  localparam logic [6:0] VIN_FLOOR_CODE_MAX = 7'h65;
  localparam logic [5:0] IIN_CAP_CODE_MAX = 6'h1f;

  // Bus rates; oversampling at the core clock covers both.
  localparam int CORE_CLK_HZ = 250_000_000;
  localparam int STANDARD_RATE_BPS = 100_000;
  localparam int FAST_RATE_BPS = 400_000;
  localparam int FAST_HALF_BIT_CYCLES = CORE_CLK_HZ / (2 * FAST_RATE_BPS);

  typedef enum logic [2:0] {
    st_idle, st_addr, st_reg, st_wdata, st_ack, st_tx, st_tack
  } serial_state_e;

endpackage

/* core/i2c_pin_sync.sv */
`timescale 1ns/10ps
module i2c_pin_sync
  import charger_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop,
  output logic o_sda
);

  logic scl_meta;
  logic scl_sync;
  logic scl_last;
  logic sda_meta;
  logic sda_sync;
  logic sda_last;

  // Both lines take the same path so their relative order survives the crossing.
  // A fast-rate half bit spans FAST_HALF_BIT_CYCLES, far more than the two-cycle lag.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_last <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_last <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      scl_last <= scl_sync;
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
      sda_last <= sda_sync;
    end
  end

  assign o_scl_rise = scl_sync && !scl_last;
  assign o_scl_fall = !scl_sync && scl_last;
  assign o_start = scl_sync && scl_last && sda_last && !sda_sync;
  assign o_stop = scl_sync && scl_last && !sda_last && sda_sync;
  assign o_sda = sda_sync;

endmodule

/* core/charger_config_register_bank.sv */
`timescale 1ns/10ps
module charger_config_register_bank
  import charger_cfg_pkg::*;
#(
  // Arbitrary neutral identification value.
  parameter logic [7:0] PART_ID = 8'h5a
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_reg_reset,
  input wire logic i_wdt_expire,
  input wire logic [7:0] i_interrupt_condition_state,
  input wire logic [7:0] i_fault_condition_state,
  input wire logic [7:0] i_interrupt_event_latch,
  input wire logic [7:0] i_fault_event_latch,
  output logic [7:0] o_charge_voltage_code,
  output logic [6:0] o_fast_charge_current_code,
  output logic [6:0] o_input_voltage_floor_code,
  output logic [5:0] o_input_current_cap_code
);

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_in;
  serial_state_e state;
  serial_state_e after_ack;
  serial_state_e next_after;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic byte_done;
  logic byte_ok;
  logic wr_en;
  logic [7:0] cfg [NUM_REGS];

  i2c_pin_sync i_i2c_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl_rise(scl_rise),
    .o_scl_fall(scl_fall),
    .o_start(bus_start),
    .o_stop(bus_stop),
    .o_sda(sda_in)
  );

  function automatic logic [7:0] reset_of(input int idx);
    if (idx == int'(OFS_PART_IDENTIFICATION)) begin
      return PART_ID;
    end
    return RESET_VALUE[idx];
  endfunction

  assign byte_done = scl_fall && bitcnt == 4'd8;

  always_comb begin
    byte_ok = 1'b0;
    next_after = st_idle;
    case (state)
      st_addr: begin
        byte_ok = shreg[7:1] == SLAVE_ADDR;
        next_after = shreg[0] ? st_tx : st_reg;
      end
      st_reg: begin
        byte_ok = shreg <= LAST_OFFSET;
        next_after = st_wdata;
      end
      st_wdata: begin
        byte_ok = ptr <= LAST_OFFSET;
        next_after = st_wdata;
      end
      default: begin
        byte_ok = 1'b0;
        next_after = st_idle;
      end
    endcase
  end

  assign wr_en = state == st_wdata && byte_done && byte_ok;

  // Status and latch offsets come straight from the charger core.
  always_comb begin
    case (ptr)
      OFS_INTERRUPT_CONDITION_STATE: next_tx_byte = i_interrupt_condition_state;
      OFS_FAULT_CONDITION_STATE: next_tx_byte = i_fault_condition_state;
      OFS_INTERRUPT_EVENT_LATCH: next_tx_byte = i_interrupt_event_latch;
      OFS_FAULT_EVENT_LATCH: next_tx_byte = i_fault_event_latch;
      default: begin
        if (ptr > LAST_OFFSET) begin
          next_tx_byte = BEYOND_MAP_VALUE;
        end else begin
          next_tx_byte = cfg[ptr[3:0]];
        end
      end
    endcase
  end

  // Start and stop override every state, so a repeated start needs no special path.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= st_idle;
      after_ack <= st_idle;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx_byte <= 8'h00;
      o_sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
      state <= st_idle;
      o_sda_oe_n <= 1'b1;
    end else if (bus_start) begin
      state <= st_addr;
      bitcnt <= 4'h0;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state)
        st_addr, st_reg, st_wdata: begin
          if (scl_rise && bitcnt < 4'd8) begin
            shreg <= {shreg[6:0], sda_in};
            bitcnt <= bitcnt + 4'd1;
          end else if (byte_done) begin
            bitcnt <= 4'h0;
            if (byte_ok) begin
              o_sda_oe_n <= 1'b0;
              after_ack <= next_after;
              state <= st_ack;
            end else begin
              state <= st_idle;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            state <= after_ack;
            if (after_ack == st_tx) begin
              tx_byte <= next_tx_byte;
              o_sda_oe_n <= next_tx_byte[7];
            end else begin
              o_sda_oe_n <= 1'b1;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            if (bitcnt == 4'd7) begin
              o_sda_oe_n <= 1'b1;
              state <= st_tack;
            end else begin
              tx_byte <= {tx_byte[6:0], 1'b0};
              o_sda_oe_n <= tx_byte[6];
              bitcnt <= bitcnt + 4'd1;
            end
          end
        end
        st_tack: begin
          // A NACK from the master ends the read; an ACK asks for the next offset.
          if (scl_rise && sda_in) begin
            state <= st_idle;
          end else if (scl_fall) begin
            tx_byte <= next_tx_byte;
            o_sda_oe_n <= next_tx_byte[7];
            bitcnt <= 4'h0;
            state <= st_tx;
          end
        end
        default: begin
          o_sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sda <= 1'b0;
    end else begin
      o_sda <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr <= 8'h00;
    end else if (!bus_stop && !bus_start) begin
      if (state == st_reg && byte_done && byte_ok) begin
        ptr <= shreg;
      end else if (wr_en) begin
        ptr <= ptr + 8'h01;
      end else if (state == st_tack && scl_rise && !sda_in) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  // Soft reset outranks watchdog expiry, which outranks a bus write in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= reset_of(i);
      end
    end else if (i_reg_reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= reset_of(i);
      end
    end else if (i_wdt_expire) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg[i] <= (reset_of(i) & WDT_MASK[i]) | (cfg[i] & ~WDT_MASK[i]);
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (ptr[3:0] == i[3:0]) begin
          // Read-only and reserved bits keep their reset value.
          cfg[i] <= (shreg & WRITE_MASK[i]) | (reset_of(i) & ~WRITE_MASK[i]);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_charge_voltage_code <= RESET_VALUE[0];
      o_fast_charge_current_code <= RESET_VALUE[1][6:0];
      o_input_voltage_floor_code <= RESET_VALUE[2][6:0];
      o_input_current_cap_code <= RESET_VALUE[3][5:0];
    end else begin
      o_charge_voltage_code <= cfg[0];
      if (cfg[1][6:0] > FCC_CODE_MAX) begin
        o_fast_charge_current_code <= FCC_CODE_MAX;
      end else if (cfg[1][6:0] < FCC_CODE_MIN) begin
        o_fast_charge_current_code <= 7'h00;
      end else begin
        o_fast_charge_current_code <= cfg[1][6:0];
      end
      if (cfg[2][6:0] > VIN_FLOOR_CODE_MAX) begin
        o_input_voltage_floor_code <= VIN_FLOOR_CODE_MAX;
      end else begin
        o_input_voltage_floor_code <= cfg[2][6:0];
      end
      if (cfg[3][5:0] > IIN_CAP_CODE_MAX) begin
        o_input_current_cap_code <= IIN_CAP_CODE_MAX;
      end else begin
        o_input_current_cap_code <= cfg[3][5:0];
      end
    end
  end

  undef_nack_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == st_reg && byte_done && shreg > LAST_OFFSET && !bus_start && !bus_stop)
      |=> (state == st_idle && o_sda_oe_n) [*3])
    else $error("undefined offset was not refused");

  write_ack_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (wr_en && !bus_start && !bus_stop) |=> !o_sda_oe_n && state == st_ack)
    else $error("write byte to a mapped offset was not acknowledged");

  ptr_step_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == st_tack && scl_rise && !sda_in && !bus_start && !bus_stop)
      |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance after an acknowledged read byte");

  reset_vals_a: assert property (
    @(posedge i_ref_clk) $rose(i_nrst)
      |-> cfg[0] == 8'haa && cfg[1] == 8'h46 && cfg[2] == 8'h04 && cfg[3] == 8'h13)
    else $error("limit registers not at reset values");

  fcc_clamp_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cfg[1][6:0] < 7'h06) ##1 (cfg[1][6:0] < 7'h06) |-> o_fast_charge_current_code == 7'h00)
    else $error("low current code was not forced to zero");

  vin_clamp_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cfg[2][6:0] > 7'h65) |=> o_input_voltage_floor_code == 7'h65)
    else $error("voltage floor code was not clamped");

  iin_clamp_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cfg[3][5:0] > 6'h1f) |=> o_input_current_cap_code == 6'h1f)
    else $error("current cap code was not clamped");

  wdt_keep_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (i_wdt_expire && !i_reg_reset)
      |=> cfg[0] == 8'haa && cfg[1] == 8'h46 && $stable(cfg[2]) && $stable(cfg[3]))
    else $error("watchdog restore touched the wrong registers");

  beyond_ff_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == st_tack && scl_fall && ptr > LAST_OFFSET && !bus_start && !bus_stop)
      |=> tx_byte == 8'hff && o_sda_oe_n)
    else $error("read beyond the map did not return all ones");

endmodule

/* sim/i2c_host_model.sv */
`timescale 1ns/10ps
module i2c_host_model
  import charger_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // A bit is 3 slices low and 2 high, so 625 clocks: exactly the fast rate,
  // with low and high phases above the fast-mode minimums.
  localparam int SLICE = CORE_CLK_HZ / (5 * FAST_RATE_BPS);

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic slices(input int n);
    repeat (n * SLICE) @(posedge i_ref_clk);
  endtask

  // Data only moves while the clock is low; the wire is sampled mid-high.
  task automatic clock_bit(input logic b, output logic r);
    o_sda <= b;
    slices(2);
    o_scl <= 1'b1;
    slices(1);
    r = i_sda;
    slices(1);
    o_scl <= 1'b0;
    slices(1);
  endtask

  // Also serves as a repeated start when the clock is left low.
  task automatic start();
    o_sda <= 1'b1;
    slices(1);
    o_scl <= 1'b1;
    slices(2);
    o_sda <= 1'b0;
    slices(2);
    o_scl <= 1'b0;
    slices(1);
  endtask

  task automatic stop();
    o_sda <= 1'b0;
    slices(2);
    o_scl <= 1'b1;
    slices(2);
    o_sda <= 1'b1;
    slices(2);
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, ack_n);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(nack, r);
  endtask
endmodule

/* sim/test_charger_config_register_bank.sv */
`timescale 1ns/10ps
module test_charger_config_register_bank;
  import charger_cfg_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_reg_reset = 1'b0;
  logic i_wdt_expire = 1'b0;
  logic scl, host_sda, dev_sda, dev_oe_n;
  logic [7:0] cv;
  logic [6:0] fcc, floor_code;
  logic [5:0] cap;
  wire logic sda_wire;
  int errors = 0;
  int checked = 0;
  // Arbitrary identification value handed to the device.
  localparam logic [7:0] PART_CODE = 8'h5a;

  // Pull-up wire: low if either party pulls it down.
  assign sda_wire = host_sda & (dev_oe_n | dev_sda);

  always #2 i_ref_clk = ~i_ref_clk;

  charger_config_register_bank #(
    .PART_ID(PART_CODE)
  ) i_charger_config_register_bank (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n), .i_reg_reset(i_reg_reset),
    .i_wdt_expire(i_wdt_expire), .i_interrupt_condition_state(8'h00),
    .i_fault_condition_state(8'h00), .i_interrupt_event_latch(8'h00),
    .i_fault_event_latch(8'h00), .o_charge_voltage_code(cv),
    .o_fast_charge_current_code(fcc), .o_input_voltage_floor_code(floor_code),
    .o_input_current_cap_code(cap));

  i2c_host_model i_i2c_host_model (
    .i_ref_clk(i_ref_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(host_sda));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] d, input logic exp_ack_n);
    logic a;
    i_i2c_host_model.write_byte(d, a);
    check({7'h00, a}, {7'h00, exp_ack_n});
  endtask

  task automatic check_codes(input logic [7:0] c0, c1, c2, c3);
    repeat (4) @(posedge i_ref_clk);
    check(cv, c0);
    check({1'b0, fcc}, c1);
    check({1'b0, floor_code}, c2);
    check({2'b00, cap}, c3);
  endtask

  task automatic pulse(input logic wdt);
    @(posedge i_ref_clk);
    if (wdt) i_wdt_expire <= 1'b1;
    else i_reg_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_wdt_expire <= 1'b0;
    i_reg_reset <= 1'b0;
  endtask

  task automatic bad_offset();
    i_i2c_host_model.start();
    put(8'h96, 1'b0);
    put(8'h0e, 1'b1);
    i_i2c_host_model.stop();
  endtask

  // The following transaction also proves the interface went back to idle.
  // The read starts near the end of the map so that it runs past the last offset.
  task automatic reset_readback();
    logic [7:0] d;
    logic [7:0] exp [4] = '{RESET_VALUE[12], PART_CODE, BEYOND_MAP_VALUE, BEYOND_MAP_VALUE};
    check_codes(8'haa, 8'h46, 8'h04, 8'h13);
    i_i2c_host_model.start();
    put(8'h96, 1'b0);
    put(OFS_FAULT_EVENT_MASK, 1'b0);
    i_i2c_host_model.start();
    put(8'h97, 1'b0);
    for (int i = 0; i < 4; i++) begin
      i_i2c_host_model.read_byte(i == 3, d);
      check(d, exp[i]);
    end
    i_i2c_host_model.stop();
  endtask

  // Out-of-range codes land in mapped offsets only, so no reserved place is touched.
  task automatic clamp_write();
    i_i2c_host_model.start();
    put(8'h96, 1'b0);
    put(8'h00, 1'b0);
    put(8'h55, 1'b0);
    put(8'h79, 1'b0);
    put(8'hff, 1'b0);
    put(8'h3f, 1'b0);
    i_i2c_host_model.stop();
    check_codes(8'h55, 8'h78, 8'h65, 8'h1f);
    i_i2c_host_model.start();
    put(8'h96, 1'b0);
    put(OFS_FAST_CHARGE_CURRENT_LIMIT, 1'b0);
    put(8'h03, 1'b0);
    i_i2c_host_model.stop();
    check_codes(8'h55, 8'h00, 8'h65, 8'h1f);
  endtask

  task automatic reset_sources();
    pulse(1'b1);
    check_codes(8'haa, 8'h46, 8'h65, 8'h1f);
    pulse(1'b0);
    check_codes(8'haa, 8'h46, 8'h04, 8'h13);
  endtask

  task automatic conclude();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (110000) @(posedge i_ref_clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    bad_offset();
    reset_readback();
    clamp_write();
    reset_sources();
    conclude();
  end
endmodule
